// *** hdl/ddr_burst4_pkg.sv ***
package ddr_burst4_pkg;
   localparam int DATA_W = 36;
   localparam int BE_W = 4;
   localparam int LANE_W = 9;
   localparam int ADDR_W = 19;
   localparam int UPPER_W = 17;
   localparam int MEM_WORDS = 524288;
   localparam logic [1:0] LAST_BEAT = 2'h3;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_W = DATA_W + BE_W;
   localparam logic [5:0] WORDS_PER_BURST = 6'h04;
   localparam int REF_CLK_NS = 20;
   // Turnaround: a write load follows a read load by at least this many ns
   localparam int RD_BUS_NS = 160;
   localparam logic [3:0] WR_AFTER_RD_GAP = 4'(RD_BUS_NS / REF_CLK_NS - 1);
   localparam logic [2:0] RD_CAPTURE_BEATS = 3'h4;
   localparam logic [DATA_W-1:0] DQ_IDLE = '0;
   localparam logic [BE_W-1:0] BE_NONE = 4'hF;
endpackage : ddr_burst4_pkg

// *** hdl/ddr_burst4_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ddr_burst4_if;
   import ddr_burst4_pkg::*;
   // Clocks from the controller
   logic                inClkTrue;
   logic                inClkComp;
   logic                outClkTrue;
   logic                outClkComp;
   // Control and address
   logic                loadStrobeN;
   logic                readNotWrite;
   logic [UPPER_W-1:0]  upperAddress;
   logic                burstAddrBit0;
   logic                burstAddrBit1;
   logic [BE_W-1:0]     byteEnableN;
   // Shared data bus, one driver set per end
   logic [DATA_W-1:0]   dqCtrlOut;
   logic                dqCtrlOeN;
   logic [DATA_W-1:0]   dqDevOut;
   logic                dqDevOeN;
   wire  [DATA_W-1:0]   dqBus;
   // Echo clocks
   logic                echoClockTrue;
   logic                echoClockComp;

   // A released bus settles to the idle level
   assign dqBus = !dqDevOeN ? dqDevOut : (!dqCtrlOeN ? dqCtrlOut : DQ_IDLE);

   modport ctrl (
      output inClkTrue, inClkComp, outClkTrue, outClkComp,
      output loadStrobeN, readNotWrite, upperAddress, burstAddrBit0, burstAddrBit1,
      output byteEnableN, dqCtrlOut, dqCtrlOeN,
      input  dqBus, echoClockTrue, echoClockComp
   );
   modport dev (
      input  inClkTrue, inClkComp, outClkTrue, outClkComp,
      input  loadStrobeN, readNotWrite, upperAddress, burstAddrBit0, burstAddrBit1,
      input  byteEnableN, dqBus,
      output dqDevOut, dqDevOeN, echoClockTrue, echoClockComp
   );
endinterface : ddr_burst4_if
`default_nettype wire

// *** hdl/ddr_burst4_device.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddr_burst4_device
   import ddr_burst4_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       srst,
   // Memory port
   ddr_burst4_if.dev       link
);

   typedef struct packed {
      logic                kTruePrev;
      logic                kCompPrev;
      logic                cTruePrev;
      logic                cCompPrev;
      logic                busy;
      logic                isWrite;
      logic [1:0]          beat;
      logic [UPPER_W-1:0]  upper;
      logic [1:0]          low;
      logic                rdPend;
      logic [ADDR_W-1:0]   rdAddr;
      logic                oActive;
      logic [1:0]          oBeat;
      logic [ADDR_W-1:0]   oAddr;
      logic [DATA_W-1:0]   dqOut;
      logic                dqOeN;
      logic                echoT;
      logic                echoC;
   } dev_state_t;

   localparam dev_state_t RESET_STATE = '{
      kTruePrev: 1'b1, kCompPrev: 1'b1, cTruePrev: 1'b1, cCompPrev: 1'b1,
      busy: 1'b0, isWrite: 1'b0, beat: 2'h0, upper: '0, low: 2'h0,
      rdPend: 1'b0, rdAddr: '0, oActive: 1'b0, oBeat: 2'h0, oAddr: '0,
      dqOut: DQ_IDLE, dqOeN: 1'b1, echoT: 1'b0, echoC: 1'b1};

   dev_state_t          s_r;
   dev_state_t          s_nxt;
   logic [DATA_W-1:0]   mem [MEM_WORDS];

   logic                kRise;
   logic                kcRise;
   logic                useK;
   logic                oTrue;
   logic                oComp;
   logic                wrEn;
   logic [ADDR_W-1:0]   wrAddr;
   logic [DATA_W-1:0]   wrData;
   logic [BE_W-1:0]     wrBeN;
   logic [ADDR_W-1:0]   rdAt;

   ////////////////////////////////////////////////////////////////////////
   // Edge detection on the clock pins
   always_comb
   begin
      kRise  = link.inClkTrue & ~s_r.kTruePrev;
      kcRise = link.inClkComp & ~s_r.kCompPrev;
      // Both output clocks held high selects the input clocks
      useK   = link.outClkTrue & link.outClkComp;
      oTrue  = useK ? kRise : (link.outClkTrue & ~s_r.cTruePrev);
      oComp  = useK ? kcRise : (link.outClkComp & ~s_r.cCompPrev);
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus cycle sequencing and read output
   always_comb
   begin
      s_nxt = s_r;
      wrEn = 1'b0;
      wrAddr = '0;
      wrData = link.dqBus;
      wrBeN = link.byteEnableN;
      rdAt = '0;
      s_nxt.kTruePrev = link.inClkTrue;
      s_nxt.kCompPrev = link.inClkComp;
      s_nxt.cTruePrev = link.outClkTrue;
      s_nxt.cCompPrev = link.outClkComp;

      // Output side runs first so a load in the same edge wins the pending flag
      if (oTrue)
      begin
         s_nxt.echoT = 1'b1;
         s_nxt.echoC = 1'b0;
         if (s_r.oActive && s_r.oBeat == 2'h2)
         begin
            rdAt = {s_r.oAddr[ADDR_W-1:2], 2'(s_r.oAddr[1:0] + s_r.oBeat)};
            s_nxt.dqOut = mem[rdAt];
            s_nxt.oBeat = 2'h3;
         end
         else if (s_r.rdPend)
         begin
            s_nxt.rdPend = 1'b0;
            s_nxt.oActive = 1'b1;
            s_nxt.oAddr = s_r.rdAddr;
            s_nxt.oBeat = 2'h1;
            s_nxt.dqOut = mem[s_r.rdAddr];
            s_nxt.dqOeN = 1'b0;
         end
         else
         begin
            s_nxt.oActive = 1'b0;
            s_nxt.dqOeN = 1'b1;
         end
      end
      else if (oComp)
      begin
         s_nxt.echoT = 1'b0;
         s_nxt.echoC = 1'b1;
         if (s_r.oActive && s_r.oBeat[0])
         begin
            rdAt = {s_r.oAddr[ADDR_W-1:2], 2'(s_r.oAddr[1:0] + s_r.oBeat)};
            s_nxt.dqOut = mem[rdAt];
            s_nxt.oBeat = 2'(s_r.oBeat + 2'h1);
            if (s_r.oBeat == LAST_BEAT)
            begin
               s_nxt.oActive = 1'b0;
            end
         end
      end

      // Input side: control only at a true edge, data at both edges
      if (!s_r.busy)
      begin
         if (kRise && !link.loadStrobeN)
         begin
            s_nxt.busy = 1'b1;
            s_nxt.beat = 2'h1;
            s_nxt.isWrite = ~link.readNotWrite;
            s_nxt.upper = link.upperAddress;
            s_nxt.low = {link.burstAddrBit1, link.burstAddrBit0};
            if (link.readNotWrite)
            begin
               s_nxt.rdPend = 1'b1;
               s_nxt.rdAddr = {link.upperAddress, link.burstAddrBit1, link.burstAddrBit0};
            end
            else
            begin
               wrEn = 1'b1;
               wrAddr = {link.upperAddress, link.burstAddrBit1, link.burstAddrBit0};
            end
         end
      end
      else if ((s_r.beat[0] && kcRise) || (!s_r.beat[0] && kRise))
      begin
         // Address inputs are not looked at during the burst
         wrEn = s_r.isWrite;
         wrAddr = {s_r.upper, 2'(s_r.low + s_r.beat)};
         s_nxt.beat = 2'(s_r.beat + 2'h1);
         if (s_r.beat == LAST_BEAT)
         begin
            s_nxt.busy = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; no edges while stopped, so everything holds
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         s_r <= RESET_STATE;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lane-gated array write
   always_ff @(posedge ref_clk)
   begin
      if (!srst && wrEn)
      begin
         for (int i = 0; i < BE_W; i++)
         begin
            if (!wrBeN[i])
            begin
               mem[wrAddr][i*LANE_W +: LANE_W] <= wrData[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   assign link.dqDevOut = s_r.dqOut;
   assign link.dqDevOeN = s_r.dqOeN;
   assign link.echoClockTrue = s_r.echoT;
   assign link.echoClockComp = s_r.echoC;

endmodule : ddr_burst4_device
`default_nettype wire

// *** hdl/ddr_burst4_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module burst_fifo #(
   parameter int WIDTH = 40,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              srst,
   // Fill side
   input  wire logic              inValid,
   output logic                   inReady,
   input  wire logic [WIDTH-1:0]  inData,
   // Drain side
   output logic                   outValid,
   input  wire logic              outReady,
   output logic [WIDTH-1:0]       outData,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
      logic          rdy;
   } fifo_state_t;

   fifo_state_t      f_r;
   fifo_state_t      f_nxt;
   logic [WIDTH-1:0] store [DEPTH];
   logic             push;
   logic             pop;

   always_comb
   begin
      push = inValid & f_r.rdy;
      pop = outReady & (f_r.cnt != '0);
      f_nxt = f_r;
      if (push)
      begin
         f_nxt.wp = AW'(f_r.wp + 1'b1);
      end
      if (pop)
      begin
         f_nxt.rp = AW'(f_r.rp + 1'b1);
      end
      f_nxt.cnt = (AW+1)'(f_r.cnt + push - pop);
      f_nxt.rdy = f_nxt.cnt != (AW+1)'(DEPTH);
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         f_r <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
      end
      else
      begin
         f_r <= f_nxt;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (push)
      begin
         store[f_r.wp] <= inData;
      end
   end

   assign inReady = f_r.rdy;
   assign outValid = f_r.cnt != '0;
   assign outData = store[f_r.rp];
   assign level = f_r.cnt;
endmodule : burst_fifo

////////////////////////////////////////////////////////////////////////////
module ddr_burst4_ctrl
   import ddr_burst4_pkg::*;
(
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                srst,
   // Command
   input  wire logic                cmdValid,
   output logic                     cmdReady,
   input  wire logic                cmdRead,
   input  wire logic [ADDR_W-1:0]   cmdAddr,
   // Write data with per-beat lane enables, low active
   input  wire logic                wrValid,
   output logic                     wrReady,
   input  wire logic [DATA_W-1:0]   wrData,
   input  wire logic [BE_W-1:0]     wrByteEnN,
   // Read data
   output logic                     rdValid,
   output logic [DATA_W-1:0]        rdData,
   // Clock control
   input  wire logic                tieOutClk,
   input  wire logic                clkStopReq,
   output logic                     clkStopped,
   // Memory port
   ddr_burst4_if.ctrl               link
);
   typedef enum {IDLE, WAIT, BURST, STOP} ctrl_mode_t;

   typedef struct packed {
      ctrl_mode_t          mode;
      logic                isRead;
      logic [ADDR_W-1:0]   addr;
      logic [1:0]          beat;
      logic [3:0]          gap;
      logic [2:0]          rdDelay;
      logic [2:0]          capCnt;
      logic                kT;
      logic                kC;
      logic                cT;
      logic                cC;
      logic                loadN;
      logic                rnw;
      logic [DATA_W-1:0]   dq;
      logic                dqOeN;
      logic [BE_W-1:0]     beN;
      logic                rdV;
      logic [DATA_W-1:0]   rdD;
      logic                cmdRdy;
      logic                stopped;
   } ctrl_state_t;

   ctrl_state_t               c_r;
   ctrl_state_t               c_nxt;
   logic                      pop;
   logic                      fValid;
   logic [FIFO_W-1:0]         fData;
   logic [$clog2(FIFO_DEPTH):0] fLevel;

   burst_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) wrBuf (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .inValid  (wrValid),
      .inReady  (wrReady),
      .inData   ({wrByteEnN, wrData}),
      .outValid (fValid),
      .outReady (pop),
      .outData  (fData),
      .level    (fLevel)
   );

   always_comb
   begin
      c_nxt = c_r;
      pop = 1'b0;
      c_nxt.kT = ~c_r.kT;
      c_nxt.kC = c_r.kT;
      c_nxt.loadN = 1'b1;
      c_nxt.dqOeN = 1'b1;
      c_nxt.beN = BE_NONE;
      c_nxt.gap = (c_r.gap != 4'h0) ? 4'(c_r.gap - 4'h1) : 4'h0;
      // First read word is on the bus three cycles after the load is seen
      c_nxt.rdDelay = {c_r.rdDelay[1:0], 1'b0};
      c_nxt.capCnt = c_r.rdDelay[2] ? RD_CAPTURE_BEATS :
                     ((c_r.capCnt != 3'h0) ? 3'(c_r.capCnt - 3'h1) : 3'h0);
      c_nxt.rdV = c_r.capCnt != 3'h0;
      if (c_r.capCnt != 3'h0)
      begin
         c_nxt.rdD = link.dqBus;
      end
      case (c_r.mode)
         IDLE:
         begin
            if (clkStopReq && !c_r.kT && c_r.capCnt == 3'h0 && c_r.rdDelay == 3'h0)
            begin
               c_nxt.mode = STOP;
               c_nxt.kC = 1'b1;
            end
            else if (cmdValid && c_r.cmdRdy)
            begin
               c_nxt.mode = WAIT;
               c_nxt.isRead = cmdRead;
               c_nxt.addr = cmdAddr;
            end
         end
         WAIT:
         begin
            // Issue so the load lands on the next true edge
            if (!c_r.kT && (c_r.isRead ||
                (c_r.gap == 4'h0 && fLevel >= WORDS_PER_BURST)))
            begin
               c_nxt.mode = BURST;
               c_nxt.beat = 2'h1;
               c_nxt.loadN = 1'b0;
               c_nxt.rnw = c_r.isRead;
               if (c_r.isRead)
               begin
                  c_nxt.gap = WR_AFTER_RD_GAP;
                  c_nxt.rdDelay = {c_r.rdDelay[1:0], 1'b1};
               end
               else
               begin
                  pop = fValid;
                  c_nxt.dq = fData[DATA_W-1:0];
                  c_nxt.beN = fData[FIFO_W-1:DATA_W];
                  c_nxt.dqOeN = 1'b0;
               end
            end
         end
         BURST:
         begin
            if (!c_r.isRead)
            begin
               pop = fValid;
               c_nxt.dq = fData[DATA_W-1:0];
               c_nxt.beN = fData[FIFO_W-1:DATA_W];
               c_nxt.dqOeN = 1'b0;
            end
            c_nxt.beat = 2'(c_r.beat + 2'h1);
            if (c_r.beat == LAST_BEAT)
            begin
               c_nxt.mode = IDLE;
            end
         end
         STOP:
         begin
            c_nxt.kT = 1'b1;
            c_nxt.kC = 1'b1;
            if (!clkStopReq)
            begin
               c_nxt.mode = IDLE;
               c_nxt.kT = 1'b0;
            end
         end
         default:
         begin
            c_nxt.mode = IDLE;
         end
      endcase
      c_nxt.cT = tieOutClk | c_nxt.kT;
      c_nxt.cC = tieOutClk | c_nxt.kC;
      c_nxt.cmdRdy = c_nxt.mode == IDLE && !clkStopReq;
      c_nxt.stopped = c_nxt.mode == STOP;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         c_r <= '{mode: IDLE, isRead: 1'b0, addr: '0, beat: 2'h0, gap: 4'h0,
                  rdDelay: 3'h0, capCnt: 3'h0, kT: 1'b0, kC: 1'b1, cT: 1'b0,
                  cC: 1'b1, loadN: 1'b1, rnw: 1'b1, dq: DQ_IDLE, dqOeN: 1'b1,
                  beN: BE_NONE, rdV: 1'b0, rdD: DQ_IDLE, cmdRdy: 1'b0, stopped: 1'b0};
      end
      else
      begin
         c_r <= c_nxt;
      end
   end

   assign cmdReady = c_r.cmdRdy;
   assign clkStopped = c_r.stopped;
   assign rdValid = c_r.rdV;
   assign rdData = c_r.rdD;
   assign link.inClkTrue = c_r.kT;
   assign link.inClkComp = c_r.kC;
   assign link.outClkTrue = c_r.cT;
   assign link.outClkComp = c_r.cC;
   assign link.loadStrobeN = c_r.loadN;
   assign link.readNotWrite = c_r.rnw;
   assign link.upperAddress = c_r.addr[ADDR_W-1:2];
   assign link.burstAddrBit1 = c_r.addr[1];
   assign link.burstAddrBit0 = c_r.addr[0];
   assign link.byteEnableN = c_r.beN;
   assign link.dqCtrlOut = c_r.dq;
   assign link.dqCtrlOeN = c_r.dqOeN;
endmodule : ddr_burst4_ctrl
`default_nettype wire

// *** verification/ddr_burst4_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddr_burst4_asserts
   import ddr_burst4_pkg::*;
(
   // Clock and reset
   input wire logic              ref_clk,
   input wire logic              srst,
   // Link signals
   input wire logic              inClkTrue,
   input wire logic              inClkComp,
   input wire logic              loadStrobeN,
   input wire logic              readNotWrite,
   input wire logic              dqCtrlOeN,
   input wire logic              dqDevOeN,
   input wire logic [DATA_W-1:0] dqDevOut,
   input wire logic              echoClockTrue,
   input wire logic              echoClockComp
);
   logic      prevTrue_r;
   logic      inBurst_r;
   wire logic trueEdge;
   wire logic loadEdge;

   assign trueEdge = inClkTrue && !prevTrue_r;
   assign loadEdge = trueEdge && !loadStrobeN && !inBurst_r;

   // Tracks which true edges may start a burst
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         prevTrue_r <= 1'b1;
         inBurst_r  <= 1'b0;
      end
      else
      begin
         prevTrue_r <= inClkTrue;
         inBurst_r  <= loadEdge ? 1'b1 : (trueEdge ? 1'b0 : inBurst_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   sequence rd_load;
      loadEdge && readNotWrite;
   endsequence
   sequence wr_load;
      loadEdge && !readNotWrite;
   endsequence
   sequence stopped2;
      (inClkTrue && inClkComp) ##1 (inClkTrue && inClkComp);
   endsequence

   a_read_first_beat: assert property (rd_load |-> ##3 (!dqDevOeN && echoClockTrue))
      else $error("read data not driven three cycles after load");
   a_read_four_beats: assert property (rd_load |-> ##3 (!dqDevOeN) [*4])
      else $error("read burst shorter than four beats");
   a_read_comp_beat: assert property (rd_load |-> ##4 (echoClockComp && !echoClockTrue))
      else $error("second read beat not on complement edge");
   a_write_bus_quiet: assert property (wr_load |-> dqDevOeN [*4])
      else $error("device drives bus during write burst");
   a_write_data_held: assert property (wr_load |-> (!dqCtrlOeN) [*4])
      else $error("write data not driven for four beats");
   a_reset_bus_quiet: assert property ($fell(srst) |-> dqDevOeN && echoClockComp && !echoClockTrue)
      else $error("outputs not idle after reset");
   a_echo_follows: assert property ($rose(inClkTrue) |=> echoClockTrue)
      else $error("echo clock did not follow true edge");
   a_stop_hold: assert property (stopped2 |=> $stable(dqDevOut) && $stable(dqDevOeN) && $stable(echoClockTrue))
      else $error("outputs changed while clock stopped");
   a_no_bus_fight: assert property (!(!dqDevOeN && !dqCtrlOeN))
      else $error("both ends drive the data bus");
   a_load_on_true: assert property ($fell(loadStrobeN) |-> $rose(inClkTrue))
      else $error("load strobe asserted off a true edge");
endmodule : ddr_burst4_asserts
`default_nettype wire

// *** verification/ddr_burst4_sram_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddr_burst4_sram_port_tb;
   import ddr_burst4_pkg::*;
   localparam int TIMEOUT = 20000;
   logic              ref_clk;
   logic              srst;
   logic              cmdValid;
   logic              cmdReady;
   logic              cmdRead;
   logic [ADDR_W-1:0] cmdAddr;
   logic              wrValid;
   logic              wrReady;
   logic [DATA_W-1:0] wrData;
   logic [BE_W-1:0]   wrByteEnN;
   logic              rdValid;
   logic [DATA_W-1:0] rdData;
   logic              tieOutClk;
   logic              clkStopReq;
   logic              clkStopped;
   logic [DATA_W-1:0] model [logic [ADDR_W-1:0]];
   logic [DATA_W-1:0] got [$];
   int                n_errors;
   int                n_compared;
   int                cycles;

   ////////////////////////////////////////////////////////////////////////////
   ddr_burst4_if ddr_burst4_if_inst ();
   ddr_burst4_device ddr_burst4_device_inst (.ref_clk(ref_clk), .srst(srst),
      .link(ddr_burst4_if_inst.dev));
   ddr_burst4_ctrl ddr_burst4_ctrl_inst (.ref_clk(ref_clk), .srst(srst),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdAddr(cmdAddr),
      .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData), .wrByteEnN(wrByteEnN),
      .rdValid(rdValid), .rdData(rdData), .tieOutClk(tieOutClk),
      .clkStopReq(clkStopReq), .clkStopped(clkStopped), .link(ddr_burst4_if_inst.ctrl));
   ddr_burst4_asserts ddr_burst4_asserts_inst (.ref_clk(ref_clk), .srst(srst),
      .inClkTrue(ddr_burst4_if_inst.inClkTrue), .inClkComp(ddr_burst4_if_inst.inClkComp),
      .loadStrobeN(ddr_burst4_if_inst.loadStrobeN),
      .readNotWrite(ddr_burst4_if_inst.readNotWrite),
      .dqCtrlOeN(ddr_burst4_if_inst.dqCtrlOeN), .dqDevOeN(ddr_burst4_if_inst.dqDevOeN),
      .dqDevOut(ddr_burst4_if_inst.dqDevOut),
      .echoClockTrue(ddr_burst4_if_inst.echoClockTrue),
      .echoClockComp(ddr_burst4_if_inst.echoClockComp));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check_word(input string what, input logic [DATA_W-1:0] exp,
                             input logic [DATA_W-1:0] seen);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check_word

   task automatic check_bit(input string what, input logic exp, input logic seen);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %b seen %b", what, exp, seen);
      end
   endtask : check_bit

   function automatic logic [ADDR_W-1:0] beat(input logic [ADDR_W-1:0] a, input int i);
      return {a[ADDR_W-1:2], 2'(a[1:0] + i)};
   endfunction : beat

   task automatic push(input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be);
      int k;
      wrValid   <= 1'b1;
      wrData    <= d;
      wrByteEnN <= be;
      k = 0;
      do
      begin
         @(posedge ref_clk);
         k++;
      end
      while (wrReady !== 1'b1 && k < 200);
   endtask : push

   task automatic command(input logic rd, input logic [ADDR_W-1:0] a);
      int k;
      cmdValid <= 1'b1;
      cmdRead  <= rd;
      cmdAddr  <= a;
      k = 0;
      do
      begin
         @(posedge ref_clk);
         k++;
      end
      while (cmdReady !== 1'b1 && k < 400);
      cmdValid <= 1'b0;
      @(posedge ref_clk);
   endtask : command

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] s,
                     input logic [4*BE_W-1:0] be);
      logic [DATA_W-1:0] d;
      for (int i = 0; i < 4; i++)
      begin
         d = {s, 4'(i)};
         push(d, be[BE_W*i +: BE_W]);
         for (int j = 0; j < BE_W; j++)
            if (!be[BE_W*i + j])
               model[beat(a, i)][LANE_W*j +: LANE_W] = d[LANE_W*j +: LANE_W];
      end
      wrValid <= 1'b0;
      command(1'b0, a);
   endtask : wr

   task automatic expect_rd(input logic [ADDR_W-1:0] a);
      int k;
      k = 0;
      while (got.size() < 4 && k < 100)
      begin
         @(posedge ref_clk);
         k++;
      end
      for (int i = 0; i < 4; i++)
         check_word("read word", model[beat(a, i)], (got.size() > 0) ? got.pop_front() : 'x);
   endtask : expect_rd

   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      if (rdValid === 1'b1)
         got.push_back(rdData);
      cycles++;
      if (cycles == TIMEOUT)
      begin
         n_errors++;
         $display("unexpected run length: expected below %0d seen %0d", TIMEOUT, cycles);
         final_report();
      end
   end

   initial
   begin
      srst       = 1'b1;
      cmdValid   = 1'b0;
      cmdRead    = 1'b0;
      cmdAddr    = '0;
      wrValid    = 1'b0;
      wrData     = '0;
      wrByteEnN  = BE_NONE;
      tieOutClk  = 1'b0;
      clkStopReq = 1'b0;
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      // Wrapped burst order
      wr(19'h00010, 32'hA1B2_0000, 16'h0000);
      wr(19'h00016, 32'hC3D4_0000, 16'h0000);
      command(1'b1, 19'h00013);
      expect_rd(19'h00013);
      $display("test wrap done");
      // Lane enables per beat, then back-to-back reads from every start
      wr(19'h00014, 32'h5E6F_0000, 16'h0FDE);
      for (int k = 0; k < 4; k++)
         command(1'b1, 19'h00014 + 19'(k));
      for (int k = 0; k < 4; k++)
         expect_rd(19'h00014 + 19'(k));
      $display("test lanes done");
      // Buffer filled until refused, drained by writes, read on input clocks
      for (int i = 0; i < FIFO_DEPTH; i++)
      begin
         push({32'h7700_0000 + 32'(i), 4'h5}, 4'h0);
         model[19'h00100 + 19'(i)] = {32'h7700_0000 + 32'(i), 4'h5};
      end
      wrValid <= 1'b0;
      @(posedge ref_clk);
      check_bit("write ready", 1'b0, wrReady);
      for (int j = 0; j < FIFO_DEPTH / 4; j++)
         command(1'b0, 19'h00100 + 19'(4 * j));
      tieOutClk <= 1'b1;
      for (int j = 0; j < FIFO_DEPTH / 4; j++)
         command(1'b1, 19'h00100 + 19'(4 * j));
      for (int j = 0; j < FIFO_DEPTH / 4; j++)
         expect_rd(19'h00100 + 19'(4 * j));
      tieOutClk <= 1'b0;
      $display("test buffer done");
      // Clock stop and restart
      clkStopReq <= 1'b1;
      for (int k = 0; k < 50 && clkStopped !== 1'b1; k++)
         @(posedge ref_clk);
      repeat (6) @(posedge ref_clk);
      check_bit("clock stopped", 1'b1, clkStopped);
      check_bit("command ready", 1'b0, cmdReady);
      clkStopReq <= 1'b0;
      command(1'b1, 19'h00013);
      expect_rd(19'h00013);
      $display("test clock stop done");
      final_report();
   end
endmodule : ddr_burst4_sram_port_tb
`default_nettype wire
